// ===== inc/ldvc_pkg.sv
package ldvc_pkg;
	// Status pin select and indicator kind encodings
	localparam logic       STATUS_SEL_READBACK = 1'b0;
	localparam logic       STATUS_SEL_LOCK     = 1'b1;
	localparam logic       KIND_CAL_ONLY       = 1'b0;
	localparam logic       KIND_VTUNE_CAL      = 1'b1;
	// Lock delay scaling
	localparam int         LOCK_DLY_W          = 16;
	localparam int         LOCK_DLY_MULT       = 4;
	localparam int         LOCK_CNT_W          = 18;
	// Core, band and amplitude widths
	localparam int         CORE_W              = 3;
	localparam int         BAND_W              = 8;
	localparam int         AMP_W               = 9;
	localparam int         NUM_CORES           = 7;
	localparam int         BANDS_PER_CORE      = 32;
	localparam logic [2:0] CORE_MAX            = 3'h7;
	localparam logic [2:0] CORE_MIN            = 3'h1;
	// Amplitude calibration step count
	localparam logic [3:0] AMP_STEPS           = 4'h8;
	// State machine clock divider
	localparam int         SM_DIV_W            = 3;
	localparam logic [2:0] SM_DIV_MAX          = 3'h5;
	localparam int         SM_CNT_W            = 5;
	// Lock state readback codes
	localparam logic [1:0] RB_UNLOCKED         = 2'h0;
	localparam logic [1:0] RB_INVALID          = 2'h1;
	localparam logic [1:0] RB_LOCKED           = 2'h2;
	// Reset values
	localparam logic [7:0] BAND_RESET          = 8'h00;
	localparam logic [8:0] AMP_RESET           = 9'h080;

	typedef enum logic [4:0] {
		LDVC_IDLE  = 5'b00001,
		LDVC_BAND  = 5'b00010,
		LDVC_AMP   = 5'b00100,
		LDVC_DELAY = 5'b01000,
		LDVC_DONE  = 5'b10000
	} ldvc_state_t;
endpackage

// ===== logic/ldvc_sm_clk.sv
`timescale 1ns/100ps
module ldvc_sm_clk (
	// Clock and reset
	input  wire logic                          i_sys_clk,
	input  wire logic                          i_rst,
	// Reference tick and divider setting
	input  wire logic                          i_ref_tick,
	input  wire logic [ldvc_pkg::SM_DIV_W-1:0] i_div_sel,
	// Divided state machine tick
	output logic                               o_sm_tick
);
	import ldvc_pkg::*;

	logic [SM_CNT_W-1:0] cnt_reg;
	logic [SM_CNT_W-1:0] cnt_next;
	logic [SM_CNT_W-1:0] cnt_top;
	logic                tick_reg;
	logic                tick_next;
	logic [SM_DIV_W-1:0] div_lim;

	always_comb begin
		div_lim   = (i_div_sel > SM_DIV_MAX) ? SM_DIV_MAX : i_div_sel;
		cnt_top   = SM_CNT_W'((6'h01 << div_lim) - 6'h01);
		cnt_next  = cnt_reg;
		tick_next = 1'b0;
		if (i_ref_tick) begin
			if (cnt_reg >= cnt_top) begin
				cnt_next  = '0;
				tick_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + SM_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			cnt_reg  <= '0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign o_sm_tick = tick_reg;
endmodule

// ===== logic/ldvc_top.sv
`timescale 1ns/100ps
module ldvc_top (
	// Clock and reset
	input  wire logic                            i_sys_clk,
	input  wire logic                            i_rst,
	// Pins from outside the clock domain
	input  wire logic                            i_ref_input,
	input  wire logic                            i_pd_clk,
	input  wire logic                            i_loop_locked,
	input  wire logic                            i_spi_rdata,
	// Register zero write event and its fields
	input  wire logic                            i_r0_write,
	input  wire logic                            i_freq_cal_trigger,
	input  wire logic                            i_status_pin_select,
	input  wire logic                            i_mute_on_unlock,
	// Configuration
	input  wire logic                            i_lock_indicator_kind,
	input  wire logic [ldvc_pkg::LOCK_DLY_W-1:0] i_lock_delay_count,
	input  wire logic [ldvc_pkg::SM_DIV_W-1:0]   i_cal_clk_div,
	input  wire logic [ldvc_pkg::CORE_W-1:0]     i_start_core,
	input  wire logic                            i_core_override,
	input  wire logic                            i_band_override,
	input  wire logic                            i_amplitude_override,
	input  wire logic [ldvc_pkg::BAND_W-1:0]     i_band_code,
	input  wire logic [ldvc_pkg::AMP_W-1:0]      i_amplitude_code,
	input  wire logic                            i_freq_above,
	input  wire logic                            i_ref_valid,
	// Status pin
	output logic                                 o_status_out_pin,
	output logic                                 o_status_out_pin_oe,
	// Status and calibration results
	output logic [1:0]                           o_lock_state_readback,
	output logic                                 o_rf_mute,
	output logic                                 o_cal_busy,
	output logic [ldvc_pkg::CORE_W-1:0]          o_cal_core,
	output logic [ldvc_pkg::BAND_W-1:0]          o_cal_band,
	output logic [ldvc_pkg::AMP_W-1:0]           o_cal_amp
);
	import ldvc_pkg::*;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [4:0] s1_reg;
	logic [4:0] s2_reg;
	logic [4:0] s1_next;
	logic [4:0] s2_next;
	logic       ref_d_reg;
	logic       pd_d_reg;
	logic       ref_d_next;
	logic       pd_d_next;
	logic       ref_tick;
	logic       pd_tick;

	always_comb begin
		s1_next    = {i_ref_input, i_pd_clk, i_loop_locked, i_spi_rdata, i_ref_valid};
		s2_next    = s1_reg;
		ref_d_next = s2_reg[4];
		pd_d_next  = s2_reg[3];
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			s1_reg    <= '0;
			s2_reg    <= '0;
			ref_d_reg <= 1'b0;
			pd_d_reg  <= 1'b0;
		end else begin
			s1_reg    <= s1_next;
			s2_reg    <= s2_next;
			ref_d_reg <= ref_d_next;
			pd_d_reg  <= pd_d_next;
		end
	end

	assign ref_tick = s2_reg[4] & ~ref_d_reg;
	assign pd_tick  = s2_reg[3] & ~pd_d_reg;

	logic sm_tick;

	ldvc_sm_clk u_sm_clk (
		.i_sys_clk  (i_sys_clk),
		.i_rst      (i_rst),
		.i_ref_tick (ref_tick),
		.i_div_sel  (i_cal_clk_div),
		.o_sm_tick  (sm_tick)
	);

	// ----------------------------------------
	// Calibration sequencer
	// ----------------------------------------
	ldvc_state_t          state_reg;
	ldvc_state_t          state_next;
	logic [CORE_W-1:0]    core_reg;
	logic [CORE_W-1:0]    core_next;
	logic [BAND_W-1:0]    band_reg;
	logic [BAND_W-1:0]    band_next;
	logic [AMP_W-1:0]     amp_reg;
	logic [AMP_W-1:0]     amp_next;
	logic [3:0]           step_reg;
	logic [3:0]           step_next;
	logic [LOCK_CNT_W-1:0] dly_reg;
	logic [LOCK_CNT_W-1:0] dly_next;
	logic                 band_run_reg;
	logic                 band_run_next;
	logic                 pend_reg;
	logic                 pend_next;
	logic                 done_reg;
	logic                 done_next;
	logic                 vt_reg;
	logic                 vt_next;
	logic                 pin_reg;
	logic                 pin_next;
	logic                 ref_ok;
	logic [LOCK_CNT_W-1:0] dly_load;

	assign ref_ok   = s2_reg[0];
	assign dly_load = LOCK_CNT_W'(i_lock_delay_count) * LOCK_CNT_W'(LOCK_DLY_MULT);

	always_comb begin
		state_next    = state_reg;
		core_next     = core_reg;
		band_next     = band_reg;
		amp_next      = amp_reg;
		step_next     = step_reg;
		dly_next      = dly_reg;
		// Trigger field travels with the pending write
		band_run_next = band_run_reg | (i_r0_write & i_freq_cal_trigger);
		done_next     = done_reg;
		// Start request waits for a valid reference
		pend_next     = pend_reg | i_r0_write;
		case (state_reg)
			LDVC_IDLE, LDVC_DONE: begin
				if (pend_reg && ref_ok) begin
					pend_next = i_r0_write;
					done_next = 1'b0;
					band_run_next = i_r0_write & i_freq_cal_trigger;
					core_next     = i_start_core;
					if (i_band_override) begin
						band_next = i_band_code;
					end
					amp_next   = i_amplitude_override ? i_amplitude_code : AMP_RESET;
					step_next  = '0;
					state_next = (band_run_reg && !i_band_override) ? LDVC_BAND : LDVC_AMP;
					if (band_run_reg && !i_band_override) begin
						band_next = BAND_RESET;
					end
				end
			end
			LDVC_BAND: begin
				if (sm_tick) begin
					if (i_freq_above) begin
						if (band_reg == BAND_W'(BANDS_PER_CORE - 1)) begin
							if (core_reg == CORE_MAX || i_core_override) begin
								state_next = LDVC_AMP;
							end else begin
								core_next = core_reg + CORE_W'(1);
								band_next = BAND_RESET;
							end
						end else begin
							band_next = band_reg + BAND_W'(1);
						end
					end else begin
						state_next = LDVC_AMP;
					end
				end
			end
			LDVC_AMP: begin
				if (sm_tick) begin
					if (i_amplitude_override || step_reg == AMP_STEPS) begin
						state_next = LDVC_DELAY;
						dly_next   = dly_load;
					end else begin
						amp_next  = {1'b0, amp_reg[AMP_W-1:1]} | AMP_RESET;
						step_next = step_reg + 4'h1;
					end
				end
			end
			LDVC_DELAY: begin
				if (dly_reg == '0) begin
					state_next = LDVC_DONE;
					done_next  = 1'b1;
				end else if (pd_tick) begin
					dly_next = dly_reg - LOCK_CNT_W'(1);
				end
			end
			default: begin
				state_next = LDVC_IDLE;
			end
		endcase
		pin_next = done_next;
		vt_next = ref_ok ? (done_next & s2_reg[2]) : vt_reg;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state_reg    <= LDVC_IDLE;
			core_reg     <= CORE_MAX;
			band_reg     <= BAND_RESET;
			amp_reg      <= AMP_RESET;
			step_reg     <= '0;
			dly_reg      <= '0;
			band_run_reg <= 1'b0;
			pend_reg     <= 1'b0;
			done_reg     <= 1'b0;
			vt_reg       <= 1'b0;
			pin_reg      <= 1'b0;
		end else begin
			state_reg    <= state_next;
			core_reg     <= core_next;
			band_reg     <= band_next;
			amp_reg      <= amp_next;
			step_reg     <= step_next;
			dly_reg      <= dly_next;
			band_run_reg <= band_run_next;
			pend_reg     <= pend_next;
			done_reg     <= done_next;
			vt_reg       <= vt_next;
			pin_reg      <= pin_next;
		end
	end

	// ----------------------------------------
	// Status pin and outputs
	// ----------------------------------------
	logic out_reg;
	logic out_next;
	logic mute_reg;
	logic mute_next;
	logic [1:0] rb_reg;
	logic [1:0] rb_next;

	always_comb begin
		if (i_status_pin_select == STATUS_SEL_READBACK) begin
			out_next = s2_reg[1];
		end else if (i_lock_indicator_kind == KIND_CAL_ONLY) begin
			out_next = pin_reg;
		end else begin
			out_next = vt_reg;
		end
		mute_next = i_mute_on_unlock & ~vt_reg;
		rb_next = !ref_ok ? RB_INVALID : (vt_reg ? RB_LOCKED : RB_UNLOCKED);
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			out_reg  <= 1'b0;
			mute_reg <= 1'b0;
			rb_reg   <= RB_UNLOCKED;
		end else begin
			out_reg  <= out_next;
			mute_reg <= mute_next;
			rb_reg   <= rb_next;
		end
	end

	assign o_status_out_pin      = out_reg;
	assign o_status_out_pin_oe   = 1'b1;
	assign o_lock_state_readback = rb_reg;
	assign o_rf_mute             = mute_reg;
	assign o_cal_busy            = ~state_reg[0] & ~state_reg[4];
	assign o_cal_core            = core_reg;
	assign o_cal_band            = band_reg;
	assign o_cal_amp             = amp_reg;
endmodule

// ===== tb/ldvc_checker.sv
`timescale 1ns/100ps
module ldvc_checker (
	// Clock and reset
	input wire logic       i_sys_clk,
	input wire logic       i_rst,
	// Watched inputs
	input wire logic       i_loop_locked,
	input wire logic       i_spi_rdata,
	input wire logic       i_r0_write,
	input wire logic       i_status_pin_select,
	input wire logic       i_mute_on_unlock,
	input wire logic       i_lock_indicator_kind,
	input wire logic       i_ref_valid,
	// Watched outputs
	input wire logic       o_status_out_pin,
	input wire logic       o_status_out_pin_oe,
	input wire logic [1:0] o_lock_state_readback,
	input wire logic       o_rf_mute,
	input wire logic       o_cal_busy
);
	import ldvc_pkg::*;
	logic cal_only;
	assign cal_only = (i_status_pin_select == STATUS_SEL_LOCK) &&
		(i_lock_indicator_kind == KIND_CAL_ONLY);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	a_pin_always_driven: assert property (o_status_out_pin_oe)
		else $error("status pin released");
	a_readback_path: assert property ((!i_status_pin_select)[*4] |->
		o_status_out_pin == $past(i_spi_rdata, 3)) else $error("readback path wrong");
	a_write_starts_cal: assert property (i_r0_write && !o_cal_busy && i_ref_valid &&
		$past(i_ref_valid, 4) |-> ##[1:5] o_cal_busy) else $error("no cal start");
	a_low_while_busy: assert property ((cal_only && o_cal_busy)[*3] |->
		!o_status_out_pin) else $error("indicator high while busy");
	a_high_after_done: assert property ($fell(o_cal_busy) && cal_only |->
		##[1:3] o_status_out_pin) else $error("indicator not raised");
	a_indicator_holds: assert property ((cal_only && !i_r0_write)[*4] ##0
		o_status_out_pin |=> o_status_out_pin) else $error("indicator dropped");
	a_mute_clear: assert property (!i_mute_on_unlock |=> !o_rf_mute)
		else $error("mute without enable");
	a_mute_unlock: assert property ((i_mute_on_unlock && !i_loop_locked &&
		i_ref_valid)[*6] |-> o_rf_mute) else $error("no mute on unlock");
	a_rb_unlocked: assert property ((!i_loop_locked && i_ref_valid)[*5] |->
		o_lock_state_readback == RB_UNLOCKED) else $error("readback not unlocked");
endmodule

bind ldvc_top ldvc_checker u_ldvc_checker (.i_sys_clk, .i_rst, .i_loop_locked, .i_spi_rdata,
	.i_r0_write, .i_status_pin_select, .i_mute_on_unlock, .i_lock_indicator_kind,
	.i_ref_valid, .o_status_out_pin, .o_status_out_pin_oe, .o_lock_state_readback,
	.o_rf_mute, .o_cal_busy);

// ===== tb/ldvc_host_model.sv
`timescale 1ns/100ps
module ldvc_host_model (
	// Clock and requests
	input  wire logic i_sys_clk,
	input  wire logic i_go,
	input  wire logic i_trig,
	input  wire logic i_ref_on,
	// Pins towards the device
	output logic      o_r0_write,
	output logic      o_freq_cal_trigger,
	output logic      o_ref_input,
	output logic      o_pd_clk
);
	logic [1:0] ph;
	initial begin
		ph = 2'h0;
		{o_r0_write, o_freq_cal_trigger, o_ref_input, o_pd_clk} = 4'h0;
	end
	always @(posedge i_sys_clk) begin
		ph <= ph + 2'h1;
		o_ref_input <= i_ref_on & ph[1];
		o_pd_clk <= i_ref_on & ph[1];
		o_r0_write <= i_go & i_ref_on;
		o_freq_cal_trigger <= i_go ? i_trig : ~o_freq_cal_trigger;
	end
endmodule

// ===== tb/ldvc_top_tb.sv
`timescale 1ns/100ps
module ldvc_top_tb;
	import ldvc_pkg::*;
	logic i_sys_clk = 0, i_rst = 1, i_ref_input, i_pd_clk, i_loop_locked, i_spi_rdata;
	logic i_r0_write, i_freq_cal_trigger, i_status_pin_select, i_mute_on_unlock;
	logic i_lock_indicator_kind, i_core_override, i_band_override, i_amplitude_override;
	logic i_freq_above, i_ref_valid, go, trig;
	logic o_status_out_pin, o_status_out_pin_oe, o_rf_mute, o_cal_busy;
	logic [15:0] i_lock_delay_count;
	logic [2:0]  i_cal_clk_div, i_start_core, o_cal_core;
	logic [7:0]  i_band_code, o_cal_band;
	logic [8:0]  i_amplitude_code, o_cal_amp;
	logic [1:0]  o_lock_state_readback;
	logic [3:0]  hist;
	int          seed = 85, n_mismatch = 0, comparisons = 0, len, c, p;

	ldvc_top u_ldvc_top (.i_sys_clk, .i_rst, .i_ref_input, .i_pd_clk, .i_loop_locked,
		.i_spi_rdata, .i_r0_write, .i_freq_cal_trigger, .i_status_pin_select,
		.i_mute_on_unlock, .i_lock_indicator_kind, .i_lock_delay_count, .i_cal_clk_div,
		.i_start_core, .i_core_override, .i_band_override, .i_amplitude_override,
		.i_band_code, .i_amplitude_code, .i_freq_above, .i_ref_valid, .o_status_out_pin,
		.o_status_out_pin_oe, .o_lock_state_readback, .o_rf_mute, .o_cal_busy,
		.o_cal_core, .o_cal_band, .o_cal_amp);
	ldvc_host_model u_ldvc_host_model (.i_sys_clk, .i_go(go), .i_trig(trig),
		.i_ref_on(i_ref_valid), .o_r0_write(i_r0_write),
		.o_freq_cal_trigger(i_freq_cal_trigger), .o_ref_input(i_ref_input),
		.o_pd_clk(i_pd_clk));

	always #20 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) i_freq_above <= 1'($random(seed));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask
	// Write register zero, then time the busy phase
	task automatic cal(input logic t);
		int k;
		@(posedge i_sys_clk);
		go <= 1'b1;
		trig <= t;
		@(posedge i_sys_clk);
		go <= 1'b0;
		k = 0;
		while (o_cal_busy !== 1'b1 && k < 20) begin
			@(negedge i_sys_clk);
			k++;
		end
		chk(o_cal_busy, 1);
		len = 0;
		while (o_cal_busy === 1'b1 && len < 6000) begin
			@(negedge i_sys_clk);
			len++;
		end
		wait_n(3);
	endtask
	task automatic tally_and_finish;
		if (n_mismatch == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		{i_loop_locked, i_spi_rdata, i_status_pin_select, i_mute_on_unlock} = 4'h0;
		{i_lock_indicator_kind, i_core_override, i_band_override} = 3'h0;
		{i_amplitude_override, i_freq_above, go, trig, hist} = 8'h00;
		i_ref_valid = 1;
		i_lock_delay_count = 16'h0000;
		i_cal_clk_div = 3'h0;
		i_start_core = 3'h7;
		i_band_code = 8'h00;
		i_amplitude_code = 9'h000;
		repeat (12) @(posedge i_sys_clk);
		i_rst <= 0;
		wait_n(1);
		chk(o_status_out_pin_oe, 1);
		chk(o_cal_core, 7);
		// Readback mode with random serial data
		for (int k = 0; k < 40; k++) begin
			@(posedge i_sys_clk);
			hist = {hist[2:0], i_spi_rdata};
			i_spi_rdata <= 1'($random(seed));
			@(negedge i_sys_clk);
			if (k >= 3) chk(o_status_out_pin, hist[2]);
		end
		i_status_pin_select <= 1;
		{i_core_override, i_band_override, i_amplitude_override} <= 3'h7;
		i_start_core <= 3'h5;
		i_band_code <= 8'($random(seed));
		i_amplitude_code <= 9'($random(seed));
		for (int n = 0; n < 3; n++) begin
			c = (n < 2) ? n : 2 + $unsigned($random(seed)) % 40;
			i_lock_delay_count <= 16'(c);
			cal(1);
			chk(len >= 16 * c - 4 && len <= 16 * c + 16, 1);
			chk(o_status_out_pin, 1);
			chk(o_cal_band, i_band_code);
			chk(o_cal_amp, i_amplitude_code);
		end
		// Indicator holds with reference gone and lock asserted
		i_ref_valid <= 0;
		i_loop_locked <= 1;
		wait_n(20);
		chk(o_status_out_pin, 1);
		chk(o_lock_state_readback, RB_INVALID);
		i_ref_valid <= 1;
		i_loop_locked <= 0;
		wait_n(8);
		// Amplitude-only calibration across divider settings
		i_lock_delay_count <= 16'h0000;
		i_amplitude_override <= 0;
		for (int d = 0; d < 7; d++) begin
			i_cal_clk_div <= 3'(d);
			p = 4 << ((d > 5) ? 5 : d);
			cal(0);
			chk(len >= 8 * p && len <= 9 * p + 4, 1);
		end
		i_cal_clk_div <= 3'h0;
		{i_core_override, i_band_override} <= 2'h0;
		i_start_core <= 3'h7;
		cal(1);
		chk(o_cal_core, 7);
		i_start_core <= 3'h1;
		cal(1);
		chk(len < 6000 && o_cal_core >= 3'h1 && o_cal_band < 8'h20, 1);
		// Tuning-voltage indicator and mute
		i_lock_indicator_kind <= 1;
		i_mute_on_unlock <= 1;
		wait_n(8);
		chk(o_status_out_pin, 0);
		chk(o_rf_mute, 1);
		i_loop_locked <= 1;
		wait_n(8);
		chk(o_status_out_pin, 1);
		chk(o_rf_mute, 0);
		chk(o_lock_state_readback, RB_LOCKED);
		i_ref_valid <= 0;
		i_loop_locked <= 0;
		wait_n(10);
		chk(o_status_out_pin, 1);
		i_ref_valid <= 1;
		wait_n(10);
		chk(o_status_out_pin, 0);
		tally_and_finish();
	end

	initial begin
		#(40 * 40000);
		n_mismatch++;
		tally_and_finish();
	end
endmodule
